// File: adc_corr_pkg.sv
package adc_corr_pkg;
   // channel count and sample width
   localparam int NCH = 3;
   localparam int DATA_W = 24;
   localparam int PROD_W = 50;
   // calibration register parts
   localparam int CAL_HI_W = 16;
   localparam int CAL_LO_W = 8;
   localparam int GAIN_FRAC = 23;
   localparam logic [DATA_W-1:0] GAIN_UNITY = 24'h800000;
   localparam logic [DATA_W-1:0] OFFSET_ZERO = 24'h000000;
   localparam logic signed [PROD_W-1:0] SAT_MAX = 50'sh00000007fffff;
   localparam logic signed [PROD_W-1:0] SAT_MIN = -50'sh0000000800000;
   // per channel setup fields
   localparam int PHASE_W = 10;
   localparam int PGA_W = 3;
   localparam logic [PGA_W-1:0] PGA_GAIN_1 = 3'h0;
   // clock setup
   localparam int MOD_DIV = 2;
   localparam int OSR_CODE_W = 3;
   localparam int OSR_CNT_W = 15;
   localparam logic [OSR_CNT_W-1:0] OSR_BASE = 15'h0080;
   localparam logic [OSR_CODE_W-1:0] OSR_CODE_512 = 3'h2;
   // dc block filter
   localparam int DCB_SHIFT = 8;
   // output queue
   localparam int FIFO_DEPTH = 16;
   localparam int QUEUE_FRAMES = 2;
   // data ready strobe width
   localparam int CLK_PERIOD_NS = 10;
   localparam int READY_PULSE_NS = 40;
   localparam int READY_PULSE_CYC = (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CNT_W = 4;
   // correction sequencer
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_OFFS = 4'b0010,
      S_GAIN = 4'b0100,
      S_PUSH = 4'b1000
   } corr_state_e;
endpackage

// File: sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic do_wr;
   logic do_rd;

   assign in_ready = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;

   ////////////////////////////////////////////////////////////////
   // storage
   always_ff @(posedge clk) begin
      if (clk_en && do_wr) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   ////////////////////////////////////////////////////////////////
   // pointers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (clk_en) begin
         if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
         end else begin
            if (do_wr) begin
               wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
               rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
         end
      end
   end
endmodule

// File: adc_channel_correction_rate.sv
`timescale 1ns/10ps
module adc_channel_correction_rate (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic master_clock_in,
   output logic modulator_clock,
   input wire logic [adc_corr_pkg::OSR_CODE_W-1:0] oversampling_ratio,
   input wire logic [adc_corr_pkg::NCH-1:0] channel_enable,
   input wire logic high_resolution_power_mode,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::PGA_W-1:0] channel_gain_select,
   input wire logic [adc_corr_pkg::NCH-1:0] channel_input_external,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::PHASE_W-1:0] channel_phase_delay,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::CAL_HI_W-1:0] offset_cal_high,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::CAL_LO_W-1:0] offset_cal_low,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::CAL_HI_W-1:0] gain_cal_high,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::CAL_LO_W-1:0] gain_cal_low,
   input wire logic dc_block_enable,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::DATA_W-1:0] conv_data,
   output logic [adc_corr_pkg::NCH*adc_corr_pkg::PGA_W-1:0] pga_gain,
   output logic [adc_corr_pkg::NCH-1:0] input_mux_external,
   output logic power_mode_hr,
   output logic sample_ready_n,
   output logic queue_overflow,
   input wire logic word_read,
   input wire logic frame_end,
   output logic [adc_corr_pkg::DATA_W-1:0] word_data,
   output logic word_valid
);
   import adc_corr_pkg::*;

   localparam int IDX_W = $clog2(NCH + 1);
   localparam logic [IDX_W-1:0] LAST_CH = IDX_W'(NCH - 1);
   localparam logic [IDX_W-1:0] ALL_WORDS = IDX_W'(NCH);
   localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(READY_PULSE_CYC);
   localparam logic [OSR_CNT_W-1:0] ONE_CNT = 15'h0001;

   function automatic logic [OSR_CNT_W-1:0] osr_count(input logic [OSR_CODE_W-1:0] code);
      osr_count = OSR_BASE << code;
   endfunction

   function automatic logic [DATA_W-1:0] sat_word(input logic signed [PROD_W-1:0] v);
      if (v > SAT_MAX) begin
         sat_word = SAT_MAX[DATA_W-1:0];
      end else if (v < SAT_MIN) begin
         sat_word = SAT_MIN[DATA_W-1:0];
      end else begin
         sat_word = v[DATA_W-1:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // master clock sync and divide
   logic mclk_s1_reg;
   logic mclk_s2_reg;
   logic mclk_s3_reg;
   logic mod_reg;
   logic mod_tick;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mclk_s1_reg <= 1'b0;
         mclk_s2_reg <= 1'b0;
         mclk_s3_reg <= 1'b0;
      end else if (clk_en) begin
         mclk_s1_reg <= master_clock_in;
         mclk_s2_reg <= mclk_s1_reg;
         mclk_s3_reg <= mclk_s2_reg;
      end
   end

   // one modulator period per two master edges
   assign mod_tick = mclk_s2_reg && !mclk_s3_reg && mod_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mod_reg <= 1'b0;
      end else if (clk_en && mclk_s2_reg && !mclk_s3_reg) begin
         mod_reg <= !mod_reg;
      end
   end

   assign modulator_clock = mod_reg;

   ////////////////////////////////////////////////////////////////
   // setup registers
   logic [OSR_CNT_W-1:0] osr_reg;
   logic [NCH-1:0] enable_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osr_reg <= osr_count(OSR_CODE_512);
         enable_reg <= '1;
         power_mode_hr <= 1'b1;
         pga_gain <= {NCH{PGA_GAIN_1}};
         input_mux_external <= '1;
      end else if (clk_en) begin
         osr_reg <= osr_count(oversampling_ratio);
         enable_reg <= channel_enable;
         power_mode_hr <= high_resolution_power_mode;
         pga_gain <= channel_gain_select;
         input_mux_external <= channel_input_external;
      end
   end

   ////////////////////////////////////////////////////////////////
   // output rate counter
   logic [OSR_CNT_W-1:0] mod_cnt_reg;
   logic sample_tick;

   assign sample_tick = mod_tick && (mod_cnt_reg >= osr_reg - ONE_CNT);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mod_cnt_reg <= '0;
      end else if (clk_en && mod_tick) begin
         mod_cnt_reg <= sample_tick ? '0 : mod_cnt_reg + ONE_CNT;
      end
   end

   ////////////////////////////////////////////////////////////////
   // per channel phase-delayed capture
   logic [DATA_W-1:0] cap_reg [NCH];

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_cap
         logic [OSR_CNT_W-1:0] phase;
         logic hit;
         assign phase = {{(OSR_CNT_W-PHASE_W){1'b0}}, channel_phase_delay[g*PHASE_W +: PHASE_W]};
         // late phases clamp to the last slot of the period
         assign hit = mod_tick && ((mod_cnt_reg == phase) ||
                      ((phase >= osr_reg) && (mod_cnt_reg == osr_reg - ONE_CNT)));
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cap_reg[g] <= '0;
            end else if (clk_en && hit) begin
               cap_reg[g] <= conv_data[g*DATA_W +: DATA_W];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // correction sequencer
   corr_state_e state_reg;
   logic [IDX_W-1:0] ch_reg;
   logic [DATA_W-1:0] work_reg [NCH];
   logic [DATA_W-1:0] ocal_reg [NCH];
   logic [DATA_W-1:0] gcal_reg [NCH];
   logic [DATA_W-1:0] dcb_reg [NCH];
   logic signed [DATA_W:0] diff_reg;
   logic [DATA_W-1:0] res_reg;
   logic signed [DATA_W:0] off_diff;
   logic signed [DATA_W:0] dcb_diff;
   logic signed [PROD_W-1:0] product;
   logic push_valid;
   logic push_ready;
   logic push_last;
   logic frame_drop;
   logic [1:0] fifo_frames_reg;
   logic out_full_reg;
   logic [1:0] pending;

   assign pending = fifo_frames_reg + {1'b0, out_full_reg};
   assign frame_drop = sample_tick && (state_reg == S_IDLE) && (pending >= 2'(QUEUE_FRAMES));
   assign dcb_diff = $signed({work_reg[ch_reg][DATA_W-1], work_reg[ch_reg]}) -
                     $signed({dcb_reg[ch_reg][DATA_W-1], dcb_reg[ch_reg]});
   assign off_diff = dc_block_enable ? dcb_diff :
                     $signed({work_reg[ch_reg][DATA_W-1], work_reg[ch_reg]}) -
                     $signed({ocal_reg[ch_reg][DATA_W-1], ocal_reg[ch_reg]});
   assign product = PROD_W'(diff_reg * $signed({1'b0, gcal_reg[ch_reg]}));
   assign push_valid = state_reg == S_PUSH;
   assign push_last = push_valid && push_ready && (ch_reg == LAST_CH);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= S_IDLE;
         ch_reg <= '0;
      end else if (clk_en) begin
         case (state_reg)
            S_IDLE: begin
               ch_reg <= '0;
               if (sample_tick && !frame_drop) begin
                  state_reg <= S_OFFS;
               end
            end
            S_OFFS: begin
               state_reg <= S_GAIN;
            end
            S_GAIN: begin
               state_reg <= S_PUSH;
            end
            S_PUSH: begin
               if (push_ready) begin
                  ch_reg <= ch_reg + 1'b1;
                  state_reg <= (ch_reg == LAST_CH) ? S_IDLE : S_OFFS;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

   // frame snapshot of samples and calibration at the period boundary
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            work_reg[i] <= '0;
            ocal_reg[i] <= OFFSET_ZERO;
            gcal_reg[i] <= GAIN_UNITY;
         end
      end else if (clk_en && sample_tick && (state_reg == S_IDLE)) begin
         for (int i = 0; i < NCH; i++) begin
            work_reg[i] <= cap_reg[i];
            ocal_reg[i] <= {offset_cal_high[i*CAL_HI_W +: CAL_HI_W], offset_cal_low[i*CAL_LO_W +: CAL_LO_W]};
            gcal_reg[i] <= {gain_cal_high[i*CAL_HI_W +: CAL_HI_W], gain_cal_low[i*CAL_LO_W +: CAL_LO_W]};
         end
      end
   end

   // dc block estimate follows each channel slowly
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            dcb_reg[i] <= '0;
         end
      end else if (clk_en && (state_reg == S_OFFS) && dc_block_enable) begin
         dcb_reg[ch_reg] <= dcb_reg[ch_reg] + DATA_W'(dcb_diff >>> DCB_SHIFT);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         diff_reg <= '0;
         res_reg <= '0;
      end else if (clk_en) begin
         if (state_reg == S_OFFS) begin
            diff_reg <= off_diff;
         end
         if (state_reg == S_GAIN) begin
            res_reg <= enable_reg[ch_reg] ? sat_word(product >>> GAIN_FRAC) : '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // word buffer
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [DATA_W-1:0] fifo_out_data;

   sample_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .clk_en(clk_en),
      .flush(frame_drop),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(res_reg),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////
   // frame queue and host read buffer
   logic [DATA_W-1:0] frame_buf [NCH];
   logic loading_reg;
   logic [IDX_W-1:0] load_idx_reg;
   logic [IDX_W-1:0] rd_idx_reg;
   logic load_start;

   assign load_start = !out_full_reg && !loading_reg && (fifo_frames_reg != 2'h0) && !frame_drop;
   assign fifo_out_ready = loading_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fifo_frames_reg <= '0;
      end else if (clk_en) begin
         if (frame_drop) begin
            fifo_frames_reg <= '0;
         end else begin
            fifo_frames_reg <= fifo_frames_reg + {1'b0, push_last} - {1'b0, load_start};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         loading_reg <= 1'b0;
         load_idx_reg <= '0;
         out_full_reg <= 1'b0;
      end else if (clk_en) begin
         if (frame_drop) begin
            loading_reg <= 1'b0;
         end else if (load_start) begin
            loading_reg <= 1'b1;
            load_idx_reg <= '0;
         end else if (loading_reg && fifo_out_valid) begin
            load_idx_reg <= load_idx_reg + 1'b1;
            if (load_idx_reg == LAST_CH) begin
               loading_reg <= 1'b0;
               out_full_reg <= 1'b1;
            end
         end else if (frame_end && (rd_idx_reg == ALL_WORDS)) begin
            out_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && loading_reg && fifo_out_valid) begin
         frame_buf[load_idx_reg] <= fifo_out_data;
      end
   end

   // partial reads restart at the first word
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_idx_reg <= '0;
         word_data <= '0;
         word_valid <= 1'b0;
      end else if (clk_en) begin
         word_valid <= 1'b0;
         if (frame_end) begin
            rd_idx_reg <= '0;
         end else if (word_read && out_full_reg && (rd_idx_reg != ALL_WORDS)) begin
            word_data <= frame_buf[rd_idx_reg];
            word_valid <= 1'b1;
            rd_idx_reg <= rd_idx_reg + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // data ready strobe and overflow flag
   logic [PULSE_CNT_W-1:0] pulse_cnt_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pulse_cnt_reg <= '0;
         sample_ready_n <= 1'b1;
         queue_overflow <= 1'b0;
      end else if (clk_en) begin
         queue_overflow <= frame_drop;
         if (push_last) begin
            pulse_cnt_reg <= PULSE_LOAD;
            sample_ready_n <= 1'b0;
         end else if (pulse_cnt_reg > 1) begin
            pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
         end else begin
            pulse_cnt_reg <= '0;
            sample_ready_n <= 1'b1;
         end
      end
   end
endmodule

// File: adc_channel_correction_rate_props.sv
`timescale 1ns/10ps
module adc_channel_correction_rate_props (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic master_clock_in,
   input wire logic modulator_clock,
   input wire logic high_resolution_power_mode,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::PGA_W-1:0] channel_gain_select,
   input wire logic [adc_corr_pkg::NCH-1:0] channel_input_external,
   input wire logic [adc_corr_pkg::NCH*adc_corr_pkg::PGA_W-1:0] pga_gain,
   input wire logic [adc_corr_pkg::NCH-1:0] input_mux_external,
   input wire logic power_mode_hr,
   input wire logic sample_ready_n,
   input wire logic queue_overflow,
   input wire logic word_read,
   input wire logic frame_end,
   input wire logic [adc_corr_pkg::DATA_W-1:0] word_data,
   input wire logic word_valid
);
   import adc_corr_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst || !clk_en);
   ////////////////////////////////////////////////////////////////
   mod_clock_toggle_a: assert property ($rose(master_clock_in) |-> ##[1:4] $changed(modulator_clock))
      else $error("modulator clock missed a master edge");
   ready_pulse_a: assert property ($fell(sample_ready_n) |-> ##1 !sample_ready_n [*3] ##1 sample_ready_n)
      else $error("ready strobe width wrong");
   word_cause_a: assert property (word_valid |-> $past(word_read) && !$past(frame_end))
      else $error("word without a read request");
   end_wins_a: assert property (frame_end |=> !word_valid)
      else $error("word delivered after frame end");
   word_hold_a: assert property (!word_valid |-> $stable(word_data))
      else $error("read word changed without a read");
   overflow_pulse_a: assert property (queue_overflow |=> !queue_overflow)
      else $error("overflow pulse too long");
   overflow_quiet_a: assert property (queue_overflow |-> sample_ready_n [*8])
      else $error("strobe on a dropped frame");
   config_follow_a: assert property (1'b1 |=> {pga_gain, input_mux_external, power_mode_hr} ==
      $past({channel_gain_select, channel_input_external, high_resolution_power_mode}))
      else $error("setup outputs do not follow inputs");
endmodule

// File: host_model.sv
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   output logic master_clock_in,
   output logic word_read,
   output logic frame_end,
   input wire logic word_valid,
   input wire logic [adc_corr_pkg::DATA_W-1:0] word_data
);
   import adc_corr_pkg::*;
   logic [DATA_W-1:0] rd [3];
   ////////////////////////////////////////////////////////////////
   // free running master clock, 4 system cycles
   initial begin
      master_clock_in = 1'b0;
      word_read = 1'b0;
      frame_end = 1'b0;
      forever #20 master_clock_in = ~master_clock_in;
   end
   // reads n words within the period, then ends the frame
   task automatic read_frame(input int n);
      for (int i = 0; i < 3; i++) rd[i] = 'x;
      for (int i = 0; i < n; i++) begin
         @(negedge clk) word_read = 1'b1;
         @(negedge clk) word_read = 1'b0;
         if (word_valid === 1'b1) rd[i] = word_data;
      end
      @(negedge clk) frame_end = 1'b1;
      @(negedge clk) frame_end = 1'b0;
   endtask
endmodule

// File: adc_channel_correction_rate_test.sv
`timescale 1ns/10ps
module adc_channel_correction_rate_test;
   import adc_corr_pkg::*;
   logic clk, rst, master_clock_in, modulator_clock, high_resolution_power_mode, power_mode_hr;
   logic sample_ready_n, queue_overflow, word_read, frame_end, word_valid, prev;
   logic clk_en, dc_block_enable;
   logic [NCH*PHASE_W-1:0] channel_phase_delay;
   logic [OSR_CODE_W-1:0] oversampling_ratio;
   logic [NCH-1:0] channel_enable, channel_input_external, input_mux_external;
   logic [NCH*PGA_W-1:0] channel_gain_select, pga_gain;
   logic [NCH*CAL_HI_W-1:0] offset_cal_high, gain_cal_high;
   logic [NCH*CAL_LO_W-1:0] offset_cal_low, gain_cal_low;
   logic [NCH*DATA_W-1:0] conv_data;
   logic [DATA_W-1:0] word_data, xin [3], off [3], gn [3], e [3];
   int n_fail = 0, n_checks = 0, cyc = 0, t0, t1, k, n;
   adc_channel_correction_rate i_adc_channel_correction_rate (
      .clk(clk), .rst(rst), .clk_en(clk_en), .master_clock_in(master_clock_in),
      .modulator_clock(modulator_clock), .oversampling_ratio(oversampling_ratio),
      .channel_enable(channel_enable), .high_resolution_power_mode(high_resolution_power_mode),
      .channel_gain_select(channel_gain_select), .channel_input_external(channel_input_external),
      .channel_phase_delay(channel_phase_delay),
      .offset_cal_high(offset_cal_high), .offset_cal_low(offset_cal_low),
      .gain_cal_high(gain_cal_high), .gain_cal_low(gain_cal_low), .dc_block_enable(dc_block_enable),
      .conv_data(conv_data), .pga_gain(pga_gain), .input_mux_external(input_mux_external),
      .power_mode_hr(power_mode_hr), .sample_ready_n(sample_ready_n), .queue_overflow(queue_overflow),
      .word_read(word_read), .frame_end(frame_end), .word_data(word_data), .word_valid(word_valid));
   host_model i_host_model (.clk(clk), .master_clock_in(master_clock_in), .word_read(word_read),
      .frame_end(frame_end), .word_valid(word_valid), .word_data(word_data));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check_num(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [DATA_W-1:0] corr(input logic [23:0] x, input logic [23:0] o, input logic [23:0] g);
      logic signed [PROD_W-1:0] p;
      p = ($signed({{26{x[23]}}, x}) - $signed({{26{o[23]}}, o})) * $signed({26'h0, g});
      p = p >>> GAIN_FRAC;
      if (p > SAT_MAX) p = SAT_MAX;
      else if (p < SAT_MIN) p = SAT_MIN;
      return p[DATA_W-1:0];
   endfunction
   task automatic set_cal;
      for (int c = 0; c < NCH; c++) begin
         offset_cal_high[c*CAL_HI_W +: CAL_HI_W] = off[c][23:8];
         offset_cal_low[c*CAL_LO_W +: CAL_LO_W] = off[c][7:0];
         gain_cal_high[c*CAL_HI_W +: CAL_HI_W] = gn[c][23:8];
         gain_cal_low[c*CAL_LO_W +: CAL_LO_W] = gn[c][7:0];
         conv_data[c*DATA_W +: DATA_W] = xin[c];
      end
   endtask
   task automatic expect_frame;
      for (int c = 0; c < NCH; c++) e[c] = channel_enable[c] ? corr(xin[c], off[c], gn[c]) : '0;
   endtask
   task automatic check_frame;
      for (int c = 0; c < NCH; c++) check_word(i_host_model.rd[c], e[c]);
   endtask
   task automatic wait_ready;
      int w;
      w = 0;
      while (sample_ready_n !== 1'b0 && w < 9000) begin
         @(negedge clk);
         w++;
      end
      t0 = cyc;
      check_num(32'(w < 9000), 32'h1);
      while (sample_ready_n === 1'b0) @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      dc_block_enable = 1'b0;
      channel_phase_delay = '0;
      oversampling_ratio = OSR_CODE_512;
      channel_enable = 3'h7;
      high_resolution_power_mode = 1'b0;
      channel_gain_select = {3'h3, 3'h1, PGA_GAIN_1};
      channel_input_external = 3'h5;
      xin = '{24'hfffff0, 24'h000100, 24'h123456};
      off = '{OFFSET_ZERO, OFFSET_ZERO, OFFSET_ZERO};
      gn = '{GAIN_UNITY, GAIN_UNITY, GAIN_UNITY};
      set_cal();
      repeat (3) @(negedge clk);
      check_num({pga_gain, input_mux_external, power_mode_hr, sample_ready_n, modulator_clock}, 32'h3e);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      check_num({pga_gain, input_mux_external, power_mode_hr},
         {channel_gain_select, channel_input_external, high_resolution_power_mode});
      // sample rate for ratio codes 2, 1 and 0
      for (int code = 2; code >= 0; code--) begin
         oversampling_ratio = 3'(code);
         wait_ready();
         i_host_model.read_frame(3);
         wait_ready();
         i_host_model.read_frame(3);
         t1 = t0;
         wait_ready();
         i_host_model.read_frame(3);
         check_num(32'(t0 - t1), 32'((OSR_BASE << code) * MOD_DIV * 4));
      end
      // offset then gain, old values for a delivered frame
      off = '{24'h000010, 24'h000040, OFFSET_ZERO};
      gn = '{GAIN_UNITY, 24'h400000, GAIN_UNITY};
      channel_enable = 3'h3;
      set_cal();
      wait_ready();
      expect_frame();
      off[1] = 24'h000080;
      set_cal();
      i_host_model.read_frame(3);
      check_frame();
      wait_ready();
      expect_frame();
      i_host_model.read_frame(3);
      check_frame();
      // partial read repeats the frame, empty buffer refuses
      wait_ready();
      expect_frame();
      i_host_model.read_frame(2);
      i_host_model.read_frame(3);
      check_frame();
      i_host_model.read_frame(1);
      check_word(i_host_model.rd[0], 'x);
      // dc block estimate replaces the offset values
      dc_block_enable = 1'b1;
      off = '{OFFSET_ZERO, OFFSET_ZERO, OFFSET_ZERO};
      for (int r = 0; r < 2; r++) begin
         wait_ready();
         expect_frame();
         i_host_model.read_frame(3);
         check_frame();
         for (int c = 0; c < NCH; c++) off[c] = DATA_W'($signed(xin[c]) >>> DCB_SHIFT);
      end
      dc_block_enable = 1'b0;
      // late phase on ch0 takes the new input, phase zero on ch1 the old one
      channel_phase_delay = {20'h00000, 10'h064};
      wait_ready();
      i_host_model.read_frame(3);
      off = '{OFFSET_ZERO, OFFSET_ZERO, OFFSET_ZERO};
      expect_frame();
      xin = '{24'h000200, 24'h000300, 24'h000400};
      set_cal();
      e[0] = corr(xin[0], off[0], gn[0]);
      wait_ready();
      i_host_model.read_frame(3);
      check_frame();
      // unread data overflows the queue
      k = 0;
      while (queue_overflow !== 1'b1 && k < 5000) begin
         @(negedge clk);
         k++;
      end
      check_num(32'(k < 5000), 32'h1);
      n = 0;
      prev = 1'b1;
      repeat (OSR_BASE * MOD_DIV * 4 * 6) begin
         @(negedge clk);
         if (sample_ready_n === 1'b0 && prev === 1'b1) n++;
         prev = sample_ready_n;
      end
      check_num(32'(n), 32'h3);
      // setup outputs follow, then a low clock enable freezes all state
      high_resolution_power_mode = 1'b1;
      channel_gain_select = {3'h2, 3'h4, 3'h7};
      channel_input_external = 3'h2;
      @(negedge clk);
      clk_en = 1'b0;
      check_num({pga_gain, input_mux_external, power_mode_hr}, 32'h0a75);
      prev = modulator_clock;
      high_resolution_power_mode = 1'b0;
      n = 0;
      repeat (OSR_BASE * MOD_DIV * 4 * 2) begin
         @(negedge clk);
         if (modulator_clock !== prev || power_mode_hr !== 1'b1) n++;
      end
      check_num(32'(n), 32'h0);
      clk_en = 1'b1;
      repeat (2) @(negedge clk);
      check_num(32'(power_mode_hr), 32'h0);
      wait_ready();
      summarize();
   end
endmodule
bind adc_channel_correction_rate adc_channel_correction_rate_props i_adc_channel_correction_rate_props (
   .clk(clk), .rst(rst), .clk_en(clk_en), .master_clock_in(master_clock_in), .modulator_clock(modulator_clock),
   .high_resolution_power_mode(high_resolution_power_mode), .channel_gain_select(channel_gain_select),
   .channel_input_external(channel_input_external), .pga_gain(pga_gain),
   .input_mux_external(input_mux_external), .power_mode_hr(power_mode_hr), .sample_ready_n(sample_ready_n),
   .queue_overflow(queue_overflow), .word_read(word_read), .frame_end(frame_end), .word_data(word_data),
   .word_valid(word_valid));
